// File: ieacc_regs.svh
// Register indices, field layouts, reset values and timing counts
// Assumes inclusion by the core only
`ifndef IEACC_REGS_SVH
`define IEACC_REGS_SVH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define IEACC_IDX_EN_TOP    8'h2a
`define IEACC_IDX_EN_MID    8'h2c
`define IEACC_IDX_EN_BASE   8'h3a
`define IEACC_IDX_LAT_TOP   8'h2b
`define IEACC_IDX_LAT_MID   8'h2e
`define IEACC_IDX_LAT_BASE  8'h3c
`define IEACC_IDX_STATUS    8'h30

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define IEACC_NSRC          39
`define IEACC_EF_MASK       39'h7f_ffff_bf68
`define IEACC_IL_MASK       39'h7f_ffff_bf6c
`define IEACC_NMI_SRC       6'd2
`define IEACC_PSW_IMF_BIT   4
`define IEACC_NEST_CLEAR    2'h1
`define IEACC_NEST_DEC      2'h2
`define IEACC_BANK_RST      4'h0

// ----------------------------------------------------------------
// Timing: machine cycle length and acceptance steps
// ----------------------------------------------------------------
`define IEACC_MC_CLKS       4
`define IEACC_SEQ_MCS       12
`define IEACC_MC_PUSH_FIRST 4'd1
`define IEACC_MC_PUSH_LAST  4'd5
`define IEACC_MC_VEC_FIRST  4'd6
`define IEACC_MC_VEC_LOAD   4'd9

`endif

// File: ieacc_pkg.sv
// Types shared by the acceptance core
// Assumes the register header is on the include path
package ieacc_pkg;
    typedef enum logic [0:0] {
        IEACC_IDLE = 1'b0,
        IEACC_SEQ  = 1'b1
    } ieacc_state_e;

    typedef logic [5:0]  ieacc_src_t;
    typedef logic [7:0]  ieacc_byte_t;
endpackage

// File: ieacc_save_mem.sv
// Per nesting level save store for bank select and entry flags
// Assumes one clock; read data is registered
`timescale 1ns/100ps
module ieacc_save_mem #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,    // System clock
    input  wire logic             we,     // Write strobe
    input  wire logic [AW-1:0]    waddr,  // Write level
    input  wire logic [WIDTH-1:0] wdata,  // Saved word
    input  wire logic [AW-1:0]    raddr,  // Read level
    output logic      [WIDTH-1:0] rdata_q // Registered read word
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
    end
endmodule

// File: ieacc_core.sv
// Interrupt enable gating and acceptance sequencer
// Assumes a CPU sequencer on the same clock and Avalon-MM master
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
`include "ieacc_regs.svh"

module ieacc_core
    import ieacc_pkg::*;
#(
    parameter int NSRC    = `IEACC_NSRC,
    parameter int MC_CLKS = `IEACC_MC_CLKS,
    parameter int NEST_W  = 4
) (
    input  wire logic                clk,             // 100 MHz system clock
    input  wire logic                rst,             // Async reset, active high
    input  wire logic [7:0]          avs_address,     // Byte address
    input  wire logic                avs_read,        // Read request
    input  wire logic                avs_write,       // Write request
    input  wire logic [31:0]         avs_writedata,   // Write data
    input  wire logic [3:0]          avs_byteenable,  // Byte lanes
    output logic      [31:0]         avs_readdata,    // Read data
    output logic                     avs_waitrequest, // Stall
    input  wire logic [NSRC-1:0]     src_req,         // Source set pulses
    input  wire logic                instr_last,      // Last cycle of instruction
    input  wire logic                ret_maskable,    // Maskable return executes
    input  wire logic                ret_nonmaskable, // Non-maskable return executes
    input  wire logic [15:0]         psw_in,          // Current status word
    input  wire logic [23:0]         pc_in,           // Return address
    input  wire logic [15:0]         vec_entry,       // Entry address from table
    input  wire logic [7:0]          vec_bank_code,   // Bank code from table
    output logic                     accept_start,    // Acceptance begins
    output logic                     seq_busy,        // Sequence running
    output logic                     push_we,         // Stack byte write, SP-1
    output ieacc_pkg::ieacc_byte_t   push_data,       // Stack byte
    output logic                     vec_req,         // Vector table read
    output ieacc_pkg::ieacc_src_t    vec_index,       // Vector slot
    output logic                     pc_load,         // Load program counter
    output logic      [15:0]         pc_value,        // New program counter
    output logic                     seq_done,        // Routine starts next
    output logic                     pop_req,         // Restore PC/status, SP+5
    output logic      [3:0]          bank_select,     // Register bank select
    output logic      [1:0]          nest_level,      // Nesting level field
    output logic                     master_irq_enable // Master enable
);
    import ieacc_pkg::*;

    localparam int SEQ_LAST = `IEACC_SEQ_MCS * MC_CLKS - 1;
    localparam int SEQ_GAP  = SEQ_LAST - 1;
    localparam int MCW      = $clog2(MC_CLKS + 1);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic [6:0] prio(input logic [NSRC-1:0] v);
        prio = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                prio = {1'b1, 6'(i)};
            end
        end
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] idx);
        is_addr = (a == 8'(idx << 2));
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ieacc_state_e       state_q;
    logic [NSRC-1:0]    ef_q;
    logic [NSRC-1:0]    il_q;
    logic [NSRC-1:0]    il_d;
    logic               imf_q;
    logic [NEST_W-1:0]  nest_q;
    logic [NEST_W-1:0]  depth_q;
    logic [3:0]         bank_q;
    logic [3:0]         mc_q;
    logic [MCW-1:0]     div_q;
    ieacc_src_t         src_q;
    logic [15:0]        psw_q;
    logic [23:0]        pc_q;
    logic               ack_q;
    logic [31:0]        rdata_q;
    logic [15:0]        pcv_q;
    logic [5:0]         save_rd;

    logic [NSRC-1:0]    elig;
    logic [6:0]         win;
    logic               grant;
    logic               step;
    logic               wr_go;
    logic               last_clk;
    logic               ret_any;

    assign wr_go    = avs_write & ack_q;
    assign ret_any  = ret_maskable | ret_nonmaskable;
    assign step     = (state_q == IEACC_SEQ) && (div_q == '0);
    assign last_clk = (state_q == IEACC_SEQ) && (int'(div_q) == MC_CLKS - 1)
                      && (mc_q == 4'(`IEACC_SEQ_MCS - 1));

    // ----------------------------------------------------------------
    // Arbitration
    // ----------------------------------------------------------------
    always_comb begin
        elig  = il_q & ef_q & `IEACC_EF_MASK & {NSRC{imf_q}};
        elig[`IEACC_NMI_SRC] = il_q[`IEACC_NMI_SRC];
        win   = prio(elig);
        grant = win[6] && (state_q == IEACC_IDLE) && instr_last;
    end

    assign accept_start = grant;

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata    = rdata_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (avs_read & ~ack_q) begin
            rdata_q <= 32'h0;
            if (is_addr(avs_address, `IEACC_IDX_EN_BASE)) begin
                rdata_q[15:0] <= {ef_q[15:1] & 15'(`IEACC_EF_MASK >> 1), imf_q};
            end else if (is_addr(avs_address, `IEACC_IDX_EN_MID)) begin
                rdata_q[15:0] <= ef_q[31:16];
            end else if (is_addr(avs_address, `IEACC_IDX_EN_TOP)) begin
                rdata_q[7:0] <= {1'b0, ef_q[38:32]};
            end else if (is_addr(avs_address, `IEACC_IDX_LAT_BASE)) begin
                rdata_q[15:0] <= {il_q[15:2], nest_level};
            end else if (is_addr(avs_address, `IEACC_IDX_LAT_MID)) begin
                rdata_q[15:0] <= il_q[31:16];
            end else if (is_addr(avs_address, `IEACC_IDX_LAT_TOP)) begin
                rdata_q[7:0] <= {1'b0, il_q[38:32]};
            end else if (is_addr(avs_address, `IEACC_IDX_STATUS)) begin
                rdata_q[7:0] <= {2'h0, state_q == IEACC_SEQ, 1'b0, bank_q};
            end
        end
    end

    // ----------------------------------------------------------------
    // Enable flags and master enable
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ef_q  <= '0;
            imf_q <= 1'b0;
        end else begin
            if (wr_go && is_addr(avs_address, `IEACC_IDX_EN_BASE)) begin
                {ef_q[15:1], imf_q} <= merge16({ef_q[15:1], imf_q},
                                               avs_writedata, avs_byteenable);
            end
            if (wr_go && is_addr(avs_address, `IEACC_IDX_EN_MID)) begin
                ef_q[31:16] <= merge16(ef_q[31:16], avs_writedata, avs_byteenable);
            end
            if (wr_go && is_addr(avs_address, `IEACC_IDX_EN_TOP) && avs_byteenable[0]) begin
                ef_q[38:32] <= avs_writedata[6:0];
            end
            if (ret_maskable) begin
                imf_q <= 1'b1;
            end else if (ret_nonmaskable) begin
                imf_q <= save_rd[5];
            end
            if (grant) begin
                imf_q <= 1'b0;
            end
        end
    end

    assign master_irq_enable = imf_q;

    // ----------------------------------------------------------------
    // Request latches: set wins over any clear
    // ----------------------------------------------------------------
    logic [15:0] lat_base_wr;
    assign lat_base_wr = merge16({il_q[15:2], 2'h3}, avs_writedata, avs_byteenable);

    always_comb begin
        il_d = il_q;
        if (wr_go && is_addr(avs_address, `IEACC_IDX_LAT_BASE)) begin
            il_d[15:2] = il_q[15:2] & lat_base_wr[15:2];
        end
        if (wr_go && is_addr(avs_address, `IEACC_IDX_LAT_MID)) begin
            il_d[31:16] = il_q[31:16] & merge16(il_q[31:16], avs_writedata,
                                                avs_byteenable);
        end
        if (wr_go && is_addr(avs_address, `IEACC_IDX_LAT_TOP) && avs_byteenable[0]) begin
            il_d[38:32] = il_q[38:32] & avs_writedata[6:0];
        end
        if (grant) begin
            il_d[win[5:0]] = 1'b0;
        end
        il_d = (il_d | src_req) & `IEACC_IL_MASK;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            il_q <= '0;
        end else begin
            il_q <= il_d;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer: 12 machine cycles of MC_CLKS clocks each
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= IEACC_IDLE;
            mc_q    <= 4'h0;
            div_q   <= '0;
        end else begin
            unique case (state_q)
                IEACC_IDLE: begin
                    if (grant) begin
                        state_q <= IEACC_SEQ;
                        mc_q    <= 4'h0;
                        div_q   <= MCW'(1 % MC_CLKS);
                        if (MC_CLKS == 1) begin
                            mc_q <= 4'h1;
                        end
                    end
                end
                IEACC_SEQ: begin
                    if (last_clk) begin
                        state_q <= IEACC_IDLE;
                    end else if (int'(div_q) == MC_CLKS - 1) begin
                        div_q <= '0;
                        mc_q  <= mc_q + 4'h1;
                    end else begin
                        div_q <= div_q + MCW'(1);
                    end
                end
            endcase
        end
    end

    assign seq_busy = (state_q == IEACC_SEQ);
    assign seq_done = last_clk;

    // Snapshot taken at acceptance, master enable folded in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_q <= '0;
            psw_q <= 16'h0;
            pc_q  <= 24'h0;
        end else if (grant) begin
            src_q <= win[5:0];
            psw_q <= psw_in;
            psw_q[`IEACC_PSW_IMF_BIT] <= imf_q;
            pc_q  <= pc_in;
        end
    end

    // Pushes in status high, status low, pc ext, pc high, pc low order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push_we   <= 1'b0;
            push_data <= 8'h0;
        end else begin
            push_we <= step && mc_q >= `IEACC_MC_PUSH_FIRST
                       && mc_q <= `IEACC_MC_PUSH_LAST;
            unique case (mc_q)
                4'd1:    push_data <= psw_q[15:8];
                4'd2:    push_data <= psw_q[7:0];
                4'd3:    push_data <= pc_q[23:16];
                4'd4:    push_data <= pc_q[15:8];
                default: push_data <= pc_q[7:0];
            endcase
        end
    end

    // Held through the clock at which the vector answer is taken
    assign vec_req   = seq_busy && mc_q >= `IEACC_MC_VEC_FIRST
                       && (mc_q < `IEACC_MC_VEC_LOAD || (step && mc_q == `IEACC_MC_VEC_LOAD));
    assign vec_index = src_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_load <= 1'b0;
            pcv_q   <= 16'h0;
        end else begin
            pc_load <= step && mc_q == `IEACC_MC_VEC_LOAD;
            if (step && mc_q == `IEACC_MC_VEC_LOAD) begin
                pcv_q <= vec_entry;
            end
        end
    end

    assign pc_value = pcv_q;

    // ----------------------------------------------------------------
    // Bank select, nesting counter and return handling
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bank_q <= `IEACC_BANK_RST;
        end else if (step && mc_q == `IEACC_MC_VEC_LOAD) begin
            bank_q <= bank_q + vec_bank_code[7:4];
        end else if (ret_any) begin
            bank_q <= save_rd[3:0];
        end
    end

    assign bank_select = bank_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nest_q <= '0;
        end else if (grant) begin
            nest_q <= nest_q + NEST_W'(1);
        end else if (ret_any) begin
            nest_q <= nest_q - NEST_W'(1);
        end else if (wr_go && is_addr(avs_address, `IEACC_IDX_LAT_BASE)
                     && avs_byteenable[0]) begin
            if (avs_writedata[1:0] == `IEACC_NEST_CLEAR) begin
                nest_q <= '0;
            end else if (avs_writedata[1:0] == `IEACC_NEST_DEC) begin
                nest_q <= nest_q - NEST_W'(1);
            end
        end
    end

    assign nest_level = (nest_q > NEST_W'(3)) ? 2'h3 : nest_q[1:0];

    // Save store depth; software nest writes must not move it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            depth_q <= '0;
        end else if (grant) begin
            depth_q <= depth_q + NEST_W'(1);
        end else if (ret_any) begin
            depth_q <= depth_q - NEST_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pop_req <= 1'b0;
        end else begin
            pop_req <= ret_any;
        end
    end

    ieacc_save_mem #(
        .WIDTH (6),
        .DEPTH (1 << NEST_W),
        .AW    (NEST_W)
    ) u_save (
        .clk     (clk),
        .we      (grant),
        .waddr   (depth_q),
        .wdata   ({imf_q, win[5:0] == `IEACC_NMI_SRC, bank_q}),
        .raddr   (depth_q - NEST_W'(1)),
        .rdata_q (save_rd)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [2:0] push_cnt_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push_cnt_q <= 3'h0;
        end else if (grant) begin
            push_cnt_q <= 3'h0;
        end else if (push_we) begin
            push_cnt_q <= push_cnt_q + 3'h1;
        end
    end

    master_clear_a: assert property (@(posedge clk) disable iff (rst)
        accept_start |=> !master_irq_enable) else $error("master enable not cleared");
    latch_clear_a: assert property (@(posedge clk) disable iff (rst)
        accept_start && !src_req[win[5:0]] |=> !il_q[src_q])
        else $error("accepted latch not cleared");
    master_gate_a: assert property (@(posedge clk) disable iff (rst)
        accept_start |-> (imf_q || win[5:0] == `IEACC_NMI_SRC))
        else $error("maskable taken with master off");
    source_gate_a: assert property (@(posedge clk) disable iff (rst)
        accept_start && win[5:0] != `IEACC_NMI_SRC |-> ef_q[win[5:0]])
        else $error("disabled source taken");
    seq_length_a: assert property (@(posedge clk) disable iff (rst)
        accept_start |-> ##1 (seq_busy && !seq_done) [*1] ##SEQ_GAP seq_done)
        else $error("sequence length wrong");
    push_count_a: assert property (@(posedge clk) disable iff (rst)
        seq_done |-> push_cnt_q == 3'h5) else $error("push count not five");
    maskable_return_op_master_a: assert property (@(posedge clk) disable iff (rst)
        ret_maskable && !accept_start |=> master_irq_enable && pop_req)
        else $error("maskable return did not restore");
    latch_hold_a: assert property (@(posedge clk) disable iff (rst)
        (|($past(il_q) & ~il_q)) |-> $past(accept_start) || $past(wr_go))
        else $error("latch dropped without cause");
    sample_take_a: assert property (@(posedge clk) disable iff (rst)
        !seq_busy && instr_last && (|elig) |=> seq_busy)
        else $error("eligible request not sampled");
    bank_add_a: assert property (@(posedge clk) disable iff (rst)
        pc_load |-> bank_select == $past(bank_select) + $past(vec_bank_code[7:4]))
        else $error("bank select not advanced");
endmodule

// File: ieacc_cpu_model.sv
// CPU sequencer stand-in: instruction ends and vector table answers
// Assumes the acceptance core on the same clock and reset
`timescale 1ns/100ps
module ieacc_cpu_model
    import ieacc_pkg::*;
(
    input  wire logic                  clk,          // System clock
    input  wire logic                  rst,          // Async reset
    input  wire logic                  vec_req,      // Table read
    input  wire ieacc_pkg::ieacc_src_t vec_index,    // Slot
    output logic                       instr_last,   // Last cycle
    output logic      [15:0]           vec_entry,    // Entry address
    output logic      [7:0]            vec_bank_code // Bank code
);
    logic [1:0] cnt_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_q <= 2'h0;
        else cnt_q <= cnt_q + 2'h1;
    end
    assign instr_last = (cnt_q == 2'h3);
    // Table lines toggle when not read
    assign vec_entry = vec_req ? {8'h40, 2'h0, vec_index} : {14'h0, cnt_q};
    assign vec_bank_code = vec_req ? 8'h10 : {6'h0, cnt_q};
endmodule

// File: testbench.sv
// Self-checking bench for the acceptance core
// Assumes the core, its package and the CPU model are compiled first
`timescale 1ns/100ps
module testbench;
    import ieacc_pkg::*;
    logic clk, rst, avs_read, avs_write, avs_waitrequest, instr_last, ret_maskable;
    logic ret_nonmaskable, accept_start, seq_busy, push_we, vec_req, pc_load, seq_done;
    logic pop_req, master_irq_enable;
    logic [7:0] avs_address, vec_bank_code;
    logic [31:0] avs_writedata, avs_readdata, s, r;
    logic [38:0] src_req;
    logic [15:0] psw_in, vec_entry, pc_value;
    logic [23:0] pc_in;
    logic [3:0] bank_select, avs_byteenable;
    logic [1:0] nest_level;
    ieacc_byte_t push_data;
    ieacc_src_t vec_index;
    int n_errors, total_checks;
    ieacc_core dut (.*);
    ieacc_cpu_model cpu (.*);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results();
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tmo(input int i, input int lim);
        if (i >= lim) begin
            n_errors++;
            results();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0, d};
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        tmo(i, 50);
        r = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        src_req <= 39'h1 << b;
        @(posedge clk);
        src_req <= '0;
    endtask
    task automatic ret(input logic nm);
        @(posedge clk);
        {ret_nonmaskable, ret_maskable} <= nm ? 2'h2 : 2'h1;
        @(posedge clk);
        {ret_nonmaskable, ret_maskable} <= 2'h0;
        @(negedge clk);
    endtask
    task automatic idle();
        repeat (60) begin
            @(negedge clk);
            chk(accept_start, 0);
        end
    endtask
    task automatic take(input logic m, input logic [5:0] src);
        int i;
        logic [7:0] q[$], e[$];
        e = '{psw_in[15:8], {psw_in[7:5], m, psw_in[3:0]}, pc_in[23:16], pc_in[15:8], pc_in[7:0]};
        for (i = 0; i < 200 && accept_start !== 1'b1; i++) @(negedge clk);
        tmo(i, 200);
        for (i = 0; i < 100 && seq_done !== 1'b1; i++) begin
            @(negedge clk);
            if (push_we === 1'b1) q.push_back(push_data);
            if (pc_load === 1'b1) chk(pc_value, {8'h40, 2'h0, src});
        end
        chk(i, 47);
        chk(seq_busy, 1);
        chk(q.size(), 5);
        foreach (e[k]) chk(q[k], e[k]);
        chk({master_irq_enable, bank_select, nest_level}, 7'h05);
    endtask
    initial begin
        s = 32'd8245;
        {rst, avs_read, avs_write, ret_maskable, ret_nonmaskable} = 5'h10;
        {avs_address, avs_writedata, src_req, psw_in, pc_in} = '0;
        avs_byteenable = 4'h3;
        repeat (2) @(posedge clk);
        rst <= 0;
        psw_in <= 16'(xs());
        pc_in <= 24'(xs());
        bus(0, 8'he8, 0);
        chk(r, 0);
        bus(1, 8'he8, 16'h0020);
        pulse(5);
        pulse(6);
        idle();
        bus(0, 8'hf0, 0);
        chk(r[6:5], 2'h3);
        bus(1, 8'he8, 16'h0021);
        take(1, 6'd5);
        bus(0, 8'hc0, 0);
        chk(r[7:0], 8'h01);
        bus(0, 8'hf0, 0);
        chk(r[6:0], 7'h41);
        ret(0);
        chk({pop_req, master_irq_enable, bank_select, nest_level}, 8'hc0);
        idle();
        bus(1, 8'he8, 16'h0020);
        pulse(2);
        take(0, 6'd2);
        bus(1, 8'hf0, 16'hfffe);
        @(negedge clk);
        chk(nest_level, 0);
        ret(1);
        chk({pop_req, master_irq_enable, bank_select}, 6'h20);
        bus(1, 8'hf0, 16'hfffd);
        @(negedge clk);
        chk(nest_level, 0);
        bus(1, 8'he8, 16'h0001);
        pulse(2);
        take(1, 6'd2);
        ret(1);
        chk({pop_req, master_irq_enable, bank_select}, 6'h30);
        results();
    end
endmodule
